/* logic/isf_pkg.sv */
// Purpose: constants and types for the interrupt source flag banks 3 to 6
// Assumes: serial frames of a 16-bit header then data bytes, msb first
// Notes: How it works list below
// How it works
// - a flag sets when its event occurs while its enable is high
// - reading a flag clears it only if the read returned one
// - writes never change flags; write data is ignored
// - flag contents after reset are undefined; do not rely on them
// - zero means no request pending, one means request generated
// - misc bank holds abort, starve, timeout, clear, limit, carrier
// - tx bank holds sent, sync, begin, backoff/check, starve, count, banks
// - rx bank holds timeout, level, received, len/addr, begin, preamble, cs
// - channel bank holds level, received, len/addr, begin, limit, clr, cca
// - first select picks backoff done (0) or channel check done (1)
// - second select picks frame length (0) or address filter (1)
// - third select picks channel clear (0) or reception aborted (1)
package isf_pkg;
  localparam int ADDR_W = 15;
  localparam int NBANK = 4;
  localparam logic [14:0] ADDR_MISC = 15'h00F7;
  localparam logic [14:0] ADDR_TX = 15'h00F8;
  localparam logic [14:0] ADDR_RX = 15'h00F9;
  localparam logic [14:0] ADDR_CHAN = 15'h00FA;
  localparam logic [1:0] IDX_MISC = 2'h0;
  localparam logic [1:0] IDX_TX = 2'h1;
  localparam logic [1:0] IDX_RX = 2'h2;
  localparam logic [1:0] IDX_CHAN = 2'h3;
  localparam logic [7:0] MISC_USED = 8'h9F;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  localparam logic [4:0] HDR_FIRST = 5'h00;
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [14:0] ADDR_STEP = 15'h0001;
  localparam logic [4:0] HDR_STEP = 5'h01;
  localparam logic [2:0] BIT_STEP = 3'h1;
  typedef enum logic {
    ISF_HDR = 1'b0,
    ISF_DATA = 1'b1
  } isf_phase_e;
endpackage

/* logic/isf_flag_regs.sv */
// Purpose: source flag banks 3 to 6 with read-to-clear over the serial port
// Assumes: events and enables come from logic on clock; serial pins do not
// Notes: snapshot is frozen per frame so the serial side reads stable data
// Notes: the clear is applied once per frame, after select rises again
// Notes: flags that were zero in the snapshot are never cleared by a frame
// Notes: serial side is not frozen by clock_enable; only system state is
// Notes: a read loads a byte only when its first bit is due
`timescale 1ns/1ns
module isf_flag_regs (
  // system clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // serial register port
  input wire logic serial_clock,
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // enables per bank, from the enable registers
  input wire logic [7:0] enable_misc,
  input wire logic [7:0] enable_tx,
  input wire logic [7:0] enable_rx,
  input wire logic [7:0] enable_chan,
  // source selection controls
  input wire logic backoff_or_check_select,
  input wire logic length_or_address_select,
  input wire logic clearance_or_abort_select,
  // event pulses
  input wire logic rx_aborted_event,
  input wire logic tx_starved_event,
  input wire logic rx_timeout_event,
  input wire logic channel_clear_event,
  input wire logic channel_check_limit_event,
  input wire logic carrier_detect_event,
  input wire logic frame_sent_event,
  input wire logic sync_sent_event,
  input wire logic tx_begin_event,
  input wire logic backoff_access_done_event,
  input wire logic tx_byte_count_event,
  input wire logic tx_bank_one_done_event,
  input wire logic tx_bank_zero_done_event,
  input wire logic rx_level_event,
  input wire logic frame_received_event,
  input wire logic frame_length_event,
  input wire logic address_filter_event,
  input wire logic rx_begin_event,
  input wire logic preamble_seen_event,
  input wire logic gain_control_done_event,
  input wire logic channel_check_done_event,
  // summary for the output pin logic
  output logic source_pending
);

  // system clock domain
  // flags live here; the serial side sees only the per-frame snapshot
  // and hands back a mask of the banks that it returned
  logic sel_meta_reg;
  logic sel_sync_reg;
  logic sel_prev_reg;
  logic [3:0][7:0] flags_reg;
  logic [3:0][7:0] flags_next;
  logic [3:0][7:0] snap_reg;
  logic [3:0][7:0] set_vec;
  logic [3:0][7:0] clr_vec;
  logic pending_reg;
  logic [3:0] mask_reg;
  wire frame_start;
  wire frame_end;
  wire backoff_or_check_event;
  wire length_or_address_match_event;
  wire clearance_or_abort_event;

  // shared-source selection
  // each select is a level from the control register; a change while an
  // event is high only moves which bank bit that single pulse lands on
  assign backoff_or_check_event = backoff_or_check_select ?
    channel_check_done_event : backoff_access_done_event;
  assign length_or_address_match_event = length_or_address_select ?
    address_filter_event : frame_length_event;
  assign clearance_or_abort_event = clearance_or_abort_select ?
    rx_aborted_event : channel_clear_event;

  // event placement, gated by enables; one marks a request
  // unused misc bits are masked so they can never hold a one
  // an event whose enable is low is dropped, not parked for later
  // carrier sense and underrun each land in two banks at once
  // level, received, begin and length or address each land in two banks
  assign set_vec[isf_pkg::IDX_MISC] = {rx_aborted_event, 1'b0, 1'b0,
    tx_starved_event, rx_timeout_event, channel_clear_event,
    channel_check_limit_event, carrier_detect_event}
    & enable_misc & isf_pkg::MISC_USED;
  assign set_vec[isf_pkg::IDX_TX] = {frame_sent_event, sync_sent_event,
    tx_begin_event, backoff_or_check_event, tx_starved_event,
    tx_byte_count_event, tx_bank_one_done_event, tx_bank_zero_done_event}
    & enable_tx;
  assign set_vec[isf_pkg::IDX_RX] = {rx_timeout_event, rx_level_event,
    frame_received_event, length_or_address_match_event, rx_begin_event,
    preamble_seen_event, carrier_detect_event, gain_control_done_event}
    & enable_rx;
  assign set_vec[isf_pkg::IDX_CHAN] = {rx_level_event, frame_received_event,
    length_or_address_match_event, rx_begin_event,
    channel_check_limit_event, clearance_or_abort_event,
    channel_check_done_event, backoff_access_done_event}
    & enable_chan;

  // frame edges seen through the synchroniser
  // frame_start is the falling select, frame_end the rising one
  // start takes the snapshot, end applies the clear; both need clock_enable
  // high, or the frame is missed and the flags stay as they were
  assign frame_start = sel_prev_reg & ~sel_sync_reg;
  assign frame_end = ~sel_prev_reg & sel_sync_reg;

  // clear only bits that were read as one; set wins over clear
  // the mask comes from the serial side, but it only changes while select
  // is low, so it is settled by the time the synchronised end edge arrives
  // a bit that was zero in the snapshot is never cleared, even if it set
  // during the frame; that request is still pending for the next burst
  // the loop walks the four banks; each is cleared on its own mark
  always_comb begin
    for (int i = 0; i < isf_pkg::NBANK; i++) begin
      clr_vec[i] = (frame_end && mask_reg[i]) ? snap_reg[i]
        : isf_pkg::FLAG_RST;
      flags_next[i] = (flags_reg[i] & ~clr_vec[i]) | set_vec[i];
    end
  end

  // select synchroniser, idle high
  // idle high keeps a false frame edge away from the release of reset
  // the second and third stages feed logic; the first may be metastable
  // the third stage only remembers the last value for edge detection
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sel_meta_reg <= 1'b1;
      sel_sync_reg <= 1'b1;
      sel_prev_reg <= 1'b1;
    end else if (clock_enable) begin
      sel_meta_reg <= serial_select_n;
      sel_sync_reg <= sel_meta_reg;
      sel_prev_reg <= sel_sync_reg;
    end
  end

  // flag storage; reset value is not a promise to software
  // reset to zero only to keep simulation free of unknowns
  // set wins over clear, so a request in the clearing cycle survives
  // pending is registered so the output pin logic sees a clean level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flags_reg <= '0;
      pending_reg <= 1'b0;
    end else if (clock_enable) begin
      flags_reg <= flags_next;
      pending_reg <= |flags_next;
    end
  end

  // snapshot frozen for the whole frame
  // the serial side reads these bits only after the header, well after
  // this capture, so no bit of the word is sampled while it moves
  // unmapped bytes need no snapshot; they return zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      snap_reg <= '0;
    end else if (clock_enable && frame_start) begin
      snap_reg <= flags_reg;
    end
  end

  assign source_pending = pending_reg;

  // serial clock domain
  // everything below runs on the host's link clock and, except the read marks, drops back to
  // its idle state asynchronously whenever select is high
  // frame sequencing state
  isf_pkg::isf_phase_e phase_reg;
  logic [4:0] hdr_cnt_reg;
  logic [2:0] bit_cnt_reg;
  logic [15:0] hdr_reg;
  logic [14:0] addr_reg;
  logic rd_reg;
  logic [7:0] tx_reg;
  logic out_reg;
  logic oe_reg;
  // decode and load paths
  wire frame_rst;
  wire [15:0] hdr_shift;
  wire hdr_done;
  wire byte_done;
  wire load_now;
  wire [14:0] addr_inc;
  wire [14:0] load_addr;
  wire [3:0] load_hit;
  wire [7:0] load_data;
  wire first_edge;

  // counters drop back while the host is not selecting
  // a cut frame therefore leaves no half-shifted header behind
  assign frame_rst = reset | serial_select_n;
  // header bits enter msb first: direction, then fifteen address bits
  assign hdr_shift = {hdr_reg[14:0], serial_data_in};
  assign hdr_done = (phase_reg == isf_pkg::ISF_HDR)
    && (hdr_cnt_reg == isf_pkg::HDR_LAST);
  assign byte_done = (phase_reg == isf_pkg::ISF_DATA)
    && (bit_cnt_reg == isf_pkg::BYTE_LAST);
  assign first_edge = (phase_reg == isf_pkg::ISF_HDR)
    && (hdr_cnt_reg == isf_pkg::HDR_FIRST);
  // only reads load data; write frames never reach the flags
  // a read loads at the end of the header and at every byte boundary
  assign load_now = (hdr_done && hdr_shift[15])
    || (byte_done && rd_reg);
  assign addr_inc = addr_reg + isf_pkg::ADDR_STEP;
  assign load_addr = hdr_done ? hdr_shift[14:0] : addr_inc;

  // read decode; unmapped addresses return zero and mark nothing
  // addresses past the last bank read zero, so a full burst of eight
  // bytes is harmless whatever address the host begins at
  assign load_hit[isf_pkg::IDX_MISC] = load_addr == isf_pkg::ADDR_MISC;
  assign load_hit[isf_pkg::IDX_TX] = load_addr == isf_pkg::ADDR_TX;
  assign load_hit[isf_pkg::IDX_RX] = load_addr == isf_pkg::ADDR_RX;
  assign load_hit[isf_pkg::IDX_CHAN] = load_addr == isf_pkg::ADDR_CHAN;
  assign load_data =
    load_hit[isf_pkg::IDX_MISC] ? snap_reg[isf_pkg::IDX_MISC] :
    load_hit[isf_pkg::IDX_TX] ? snap_reg[isf_pkg::IDX_TX] :
    load_hit[isf_pkg::IDX_RX] ? snap_reg[isf_pkg::IDX_RX] :
    load_hit[isf_pkg::IDX_CHAN] ? snap_reg[isf_pkg::IDX_CHAN] :
    isf_pkg::RDATA_NONE;

  // header and byte sequencing
  // the header counter stops mattering once the data phase begins
  always_ff @(posedge serial_clock or posedge frame_rst) begin
    if (frame_rst) begin
      phase_reg <= isf_pkg::ISF_HDR;
      hdr_cnt_reg <= isf_pkg::HDR_FIRST;
      bit_cnt_reg <= '0;
      hdr_reg <= '0;
    end else begin
      unique case (phase_reg)
        isf_pkg::ISF_HDR: begin
          hdr_reg <= hdr_shift;
          hdr_cnt_reg <= hdr_cnt_reg + isf_pkg::HDR_STEP;
          if (hdr_done) begin
            phase_reg <= isf_pkg::ISF_DATA;
          end
        end
        isf_pkg::ISF_DATA: begin
          bit_cnt_reg <= bit_cnt_reg + isf_pkg::BIT_STEP;
        end
      endcase
    end
  end

  // address, direction and read shifter
  // the direction bit is kept for the whole frame
  // a partial byte at the end of a frame still counts as read
  always_ff @(posedge serial_clock or posedge frame_rst) begin
    if (frame_rst) begin
      addr_reg <= '0;
      rd_reg <= 1'b0;
      tx_reg <= '0;
    end else begin
      if (hdr_done) begin
        rd_reg <= hdr_shift[15];
      end
      if (hdr_done || byte_done) begin
        addr_reg <= load_addr; // auto-increment for the burst
      end
      tx_reg <= load_now ? load_data : {tx_reg[6:0], 1'b0};
    end
  end

  // marks of registers returned this frame, kept past deselect
  // cleared on the first edge of the next frame, never on deselect,
  // so the system side can still read it after select rises
  // unmapped addresses mark nothing and so clear nothing
  always_ff @(posedge serial_clock or posedge reset) begin
    if (reset) begin
      mask_reg <= '0;
    end else if (first_edge) begin
      mask_reg <= '0;
    end else if (load_now) begin
      mask_reg <= mask_reg | load_hit;
    end
  end

  // output retimed to the falling edge
  // falling-edge launch gives the host half a period of setup
  // enable follows the direction bit, so write frames never drive
  // a deselect drops both at once, before the next clock edge
  always_ff @(negedge serial_clock or posedge frame_rst) begin
    if (frame_rst) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      out_reg <= tx_reg[7];
      oe_reg <= rd_reg;
    end
  end

  assign serial_data_out = out_reg;
  assign serial_data_oe = oe_reg;

endmodule

/* bench/isf_flag_regs_monitor.sv */
// Purpose: port checks for the flag banks
// Assumes: host frames follow the serial contract
// Notes: serial helpers clear while select is high
`timescale 1ns/1ns
module isf_monitor (
  // system side
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic [7:0] enable_misc,
  input wire logic [7:0] enable_rx,
  input wire logic [7:0] enable_chan,
  input wire logic rx_aborted_event,
  input wire logic gain_control_done_event,
  input wire logic channel_check_done_event,
  input wire logic source_pending,
  // serial side
  input wire logic serial_clock,
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  logic [7:0] cnt_reg;
  logic [15:0] hdr_reg;
  // address of the byte now on the data line, and its bit slot
  wire logic [14:0] byte_addr = hdr_reg[14:0] + {10'h000, cnt_reg[7:3] - 5'h02};
  wire logic data_ph = cnt_reg >= 8'h10 && hdr_reg[15];
  // count rises in a frame and capture the header
  always_ff @(posedge serial_clock or posedge serial_select_n) begin
    if (serial_select_n) begin
      cnt_reg <= 8'h00;
      hdr_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg < 8'h10)
        hdr_reg <= {hdr_reg[14:0], serial_data_in};
    end
  end
  a_misc_sets_pend:
  assert property (@(posedge clock) disable iff (reset) clock_enable &&
    rx_aborted_event && enable_misc[7] |=> source_pending) else $error("misc set lost");
  a_rx_sets_pend:
  assert property (@(posedge clock) disable iff (reset) clock_enable &&
    gain_control_done_event && enable_rx[0] |=> source_pending) else $error("rx set lost");
  a_chan_sets_pend:
  assert property (@(posedge clock) disable iff (reset) clock_enable &&
    channel_check_done_event && enable_chan[1] |=> source_pending) else $error("chan set lost");
  a_oe_idle_off:
  assert property (@(posedge clock) disable iff (reset)
    serial_select_n |-> !serial_data_oe) else $error("oe outside frame");
  a_oe_read_only:
  assert property (@(posedge serial_clock) disable iff (reset || serial_select_n)
    serial_data_oe == data_ph) else $error("oe phase wrong");
  a_unmapped_zero:
  assert property (@(posedge serial_clock) disable iff (reset || serial_select_n)
    data_ph && (byte_addr < 15'h00F7 || byte_addr > 15'h00FA) |-> !serial_data_out)
    else $error("unmapped byte not zero");
  a_spare_bits_zero:
  assert property (@(posedge serial_clock) disable iff (reset || serial_select_n)
    data_ph && byte_addr == isf_pkg::ADDR_MISC && cnt_reg[2:0] inside {3'h1, 3'h2}
    |-> !serial_data_out) else $error("spare bit set");
  a_clear_at_end:
  assert property (@(posedge clock) disable iff (reset)
    $fell(source_pending) |-> serial_select_n) else $error("clear inside frame");
endmodule
bind isf_flag_regs isf_monitor isf_monitor_inst (.clock(clock), .reset(reset),
  .clock_enable(clock_enable), .enable_misc(enable_misc), .enable_rx(enable_rx),
  .enable_chan(enable_chan), .rx_aborted_event(rx_aborted_event),
  .gain_control_done_event(gain_control_done_event),
  .channel_check_done_event(channel_check_done_event),
  .source_pending(source_pending), .serial_clock(serial_clock),
  .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));

/* bench/isf_host_model.sv */
// Purpose: host on the serial register port
// Assumes: 16-bit header, msb first, mode 0
// Notes: link clock runs only inside frames
`timescale 1ns/1ns
module isf_host_model (
  // serial pins
  output logic serial_clock,
  output logic serial_select_n,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  // idle pins
  initial begin
    serial_clock = 1'b0;
    serial_select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // one frame of n bytes; clears flags only by reading
  task automatic frame(input logic rw, input logic [14:0] addr,
      input int nbytes, input logic [7:0] wdata, output logic [63:0] rdata);
    logic [15:0] hdr;
    hdr = {rw, addr};
    rdata = 64'h0;
    serial_select_n = 1'b0; // held low for the whole burst
    #50;
    for (int i = 0; i < 16 + 8 * nbytes; i++) begin
      serial_data_in = (i < 16) ? hdr[15 - i] : wdata[7 - i % 8];
      #3 serial_clock = 1'b1;
      rdata = {rdata[62:0], serial_data_out};
      #3 serial_clock = 1'b0;
    end
    serial_data_in = ~serial_data_in; // released line shows no stale bit
    serial_select_n = 1'b1;
    #80;
  endtask
endmodule

/* bench/irq_source_flag_regs_3_to_6_tb.sv */
// Purpose: self-checking bench for flag banks 3 to 6
// Assumes: host model reads 0xF4..0xFB per burst
// Notes: start flags are cleared by a dummy read
`timescale 1ns/1ns
module irq_source_flag_regs_3_to_6_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [7:0] en = 8'hFF;
  logic [2:0] sel = 3'h0;
  logic [20:0] ev = 21'h000000;
  wire logic sck, ssn, sdi, sdo, soe, pend;
  logic [63:0] rd;
  int err_count = 0;
  int cmp_count = 0;
  // expected {misc,tx,rx,chan} per single event, selects low then high
  logic [31:0] exp0 [21] = '{32'h80000000, 32'h10080000, 32'h08008000,
    32'h04000004, 32'h02000008, 32'h01000200, 32'h00800000, 32'h00400000,
    32'h00200000, 32'h00100001, 32'h00040000, 32'h00020000, 32'h00010000,
    32'h00004080, 32'h00002040, 32'h00001020, 32'h00000000, 32'h00000810,
    32'h00000400, 32'h00000100, 32'h00000002};
  logic [31:0] exp1 [21] = '{32'h80000004, 32'h10080000, 32'h08008000,
    32'h04000000, 32'h02000008, 32'h01000200, 32'h00800000, 32'h00400000,
    32'h00200000, 32'h00000001, 32'h00040000, 32'h00020000, 32'h00010000,
    32'h00004080, 32'h00002040, 32'h00000000, 32'h00001020, 32'h00000810,
    32'h00000400, 32'h00000100, 32'h00100002};
  isf_flag_regs isf_flag_regs_inst (.clock(clock), .reset(reset),
    .clock_enable(ce), .serial_clock(sck), .serial_select_n(ssn),
    .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe(soe),
    .enable_misc(en), .enable_tx(en), .enable_rx(en), .enable_chan(en),
    .backoff_or_check_select(sel[0]), .length_or_address_select(sel[1]),
    .clearance_or_abort_select(sel[2]), .rx_aborted_event(ev[0]),
    .tx_starved_event(ev[1]), .rx_timeout_event(ev[2]),
    .channel_clear_event(ev[3]), .channel_check_limit_event(ev[4]),
    .carrier_detect_event(ev[5]), .frame_sent_event(ev[6]),
    .sync_sent_event(ev[7]), .tx_begin_event(ev[8]),
    .backoff_access_done_event(ev[9]), .tx_byte_count_event(ev[10]),
    .tx_bank_one_done_event(ev[11]), .tx_bank_zero_done_event(ev[12]),
    .rx_level_event(ev[13]), .frame_received_event(ev[14]),
    .frame_length_event(ev[15]), .address_filter_event(ev[16]),
    .rx_begin_event(ev[17]), .preamble_seen_event(ev[18]),
    .gain_control_done_event(ev[19]), .channel_check_done_event(ev[20]),
    .source_pending(pend));
  isf_host_model isf_host_model_inst (.serial_clock(sck),
    .serial_select_n(ssn), .serial_data_in(sdi), .serial_data_out(sdo));
  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // eight-byte burst; only bytes four to seven are ours
  task automatic burst(input logic [31:0] want);
    isf_host_model_inst.frame(1'b1, 15'h00F4, 8, 8'h00, rd);
    check(rd, {24'h000000, want, 8'h00});
  endtask
  // one-cycle event pulse
  task automatic fire(input logic [20:0] v);
    @(posedge clock) #1 ev = v;
    @(posedge clock) #1 ev = 21'h000000;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always #5 clock = ~clock;
  // about 91 frames of 0.61 us each, doubled
  initial begin
    #130000;
    err_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    #1 reset = 1'b0;
    burst(32'h00000000); // dummy read, also checks that flags start at zero
    burst(32'h00000000);
    for (int s = 0; s < 2; s++) begin
      @(posedge clock) #1 sel = s ? 3'h7 : 3'h0;
      for (int k = 0; k < 21; k++) begin
        fire(21'h000001 << k);
        burst(s ? exp1[k] : exp0[k]);
        burst(32'h00000000);
        check({63'h0, pend}, 64'h0);
      end
    end
    @(posedge clock) #1 en = 8'h00;
    fire(21'h1FFFFF);
    @(posedge clock) #1 en = 8'hFF;
    burst(32'h00000000);
    fire(21'h1FFFFF);
    isf_host_model_inst.frame(1'b0, 15'h00F7, 1, 8'h00, rd);
    burst(32'h9FFFFFFF);
    fire(21'h1FFFBF);
    fork
      burst(32'h9F7FFFFF);
      begin
        #200;
        fire(21'h000040);
      end
    join
    burst(32'h00800000);
    print_verdict();
  end
endmodule
